// ==== rtl/pfs_pkg.sv ====
// Purpose: Shared constants and carriers for the pin function select block.
// Assumes: APB with 32-bit data; registers sit in the low bits of a word.
// Notes:   Pin indices are shared by the pad vectors and the direction, data, level and status output bits.
package pfs_pkg;

  localparam int NPIN = 6;

  // Pin indices in every pin-wide vector.
  localparam int PIN_XIN  = 0;
  localparam int PIN_XOUT = 1;
  localparam int PIN_IRQ  = 2;
  localparam int PIN_TX   = 3;
  localparam int PIN_RX   = 4;
  localparam int PIN_CLK  = 5;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SERIAL = 8'h04;
  localparam logic [7:0] OFS_DIR    = 8'h08;
  localparam logic [7:0] OFS_DATA   = 8'h0C;
  localparam logic [7:0] OFS_PULLUP = 8'h10;
  localparam logic [7:0] OFS_LEVEL  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Control register fields.
  localparam int CTRL_XTAL_SEL = 0;
  localparam int CTRL_SUB_STOP = 1;
  localparam int CTRL_FB_OFF   = 2;
  localparam int CTRL_IRQ0_EN  = 3;
  localparam int CTRL_RTC_SEL  = 4;
  localparam int CTRL_RTC_EN   = 5;
  localparam int CTRL_W        = 6;

  // Serial register fields.
  localparam int SER_MODE_LSB = 0;
  localparam int SER_SERIAL_CLOCK_DIRECTION    = 3;
  localparam int SER_OD       = 4;
  localparam int SER_W        = 5;

  // Pull-up register fields.
  localparam int PU_XIN    = 0;
  localparam int PU_IRQ    = 1;
  localparam int PU_TX     = 2;
  localparam int PU_RX_CLK = 3;
  localparam int PU_W      = 4;

  // Status register fields.
  localparam int STS_OUT_LSB = 0;
  localparam int STS_OSC_BUF = 6;
  localparam int STS_FB_ON   = 7;

  // Reset values: crystal pins selected, every direction bit an input.
  localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h01;
  localparam logic [SER_W-1:0]  SERIAL_RST = 5'h00;
  localparam logic [NPIN-1:0]   DIR_RST    = 6'h00;
  localparam logic [NPIN-1:0]   DATA_RST   = 6'h00;
  localparam logic [PU_W-1:0]   PULLUP_RST = 4'h0;

  // Serial mode codes.
  localparam logic [2:0] SMODE_PORT  = 3'h0;
  localparam logic [2:0] SMODE_CLKSY = 3'h1;

  typedef struct packed {
    logic [NPIN-1:0] level;
    logic [NPIN-1:0] drive_n;
    logic [NPIN-1:0] pull_on;
  } pfs_pads_t;

  typedef struct packed {
    logic serial_two_tx;
    logic serial_two_clock;
    logic rtc_out;
  } pfs_periph_src_t;

  typedef struct packed {
    logic osc_buffer_on;
    logic feedback_on;
    logic subclk_in;
    logic ext_irq_zero;
    logic serial_two_rx;
    logic serial_two_clock;
  } pfs_periph_dst_t;

endpackage

// ==== rtl/pfs_sync.sv ====
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Pins are quasi-static compared with pclk.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module pfs_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);

  logic meta_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ==== rtl/pfs_pad.sv ====
// Purpose: Output driver and pull-up control for one pin.
// Assumes: drive_n low means the pin is driven.
// Notes:   Open drain only pulls low and never drives high.
`timescale 1ns/1ps
module pfs_pad (
  input  wire logic use_out,
  input  wire logic data,
  input  wire logic open_drain,
  input  wire logic pull_req,
  output logic      level,
  output logic      drive_n,
  output logic      pull_on
);

  wire drive_now;

  assign drive_now = use_out & ~(open_drain & data);
  assign drive_n   = ~drive_now;
  assign level     = open_drain ? 1'b0 : data;
  assign pull_on   = pull_req & ~use_out;

endmodule

// ==== rtl/pfs_pin_select.sv ====
// Purpose: Pin function select for the sub-clock, interrupt and serial pins.
// Assumes: APB slave, zero wait states, peripherals share pclk.
// Notes:   Pin inputs are synchronised before any mux reads them.
// How it works
// - Reset selects crystal function on sub-clock pins.
// - Crystal select 0 returns pins to ports.
// - Sub-clock output pin drives latch when output.
// - Stop bit gates buffer; feedback on when 0.
// - Feedback off bit disconnects feedback resistor.
// - External clock drives inverted copy on output.
// - Interrupt pin: port, or interrupt input when enabled.
// - Serial mode drives transmit pin, else direction.
// - Open drain select makes transmit pull low only.
// - Receive data taken only while pin input.
// - Clock pin outputs RTC or serial clock.
// - Smaller variant clock pin is plain port.
// - Pull-up only while pin is input.
// - Direction bits reset to input.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module pfs_pin_select #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [pfs_pkg::NPIN-1:0] pad_in,
  output pfs_pkg::pfs_pads_t            pads,
  input  wire pfs_pkg::pfs_periph_src_t periph_src,
  output pfs_pkg::pfs_periph_dst_t      periph_dst
);

  localparam int N = pfs_pkg::NPIN;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction

  logic [pfs_pkg::CTRL_W-1:0] ctrl_reg;
  logic [pfs_pkg::SER_W-1:0]  serial_reg;
  logic [N-1:0]               dir_reg;
  logic [N-1:0]               data_reg;
  logic [pfs_pkg::PU_W-1:0]   pullup_reg;
  logic [31:0]                prdata_reg;
  logic [N-1:0]               pin_sync;

  // Address decode.
  wire sel_ctrl   = hit(paddr, pfs_pkg::OFS_CTRL);
  wire sel_serial = hit(paddr, pfs_pkg::OFS_SERIAL);
  wire sel_dir    = hit(paddr, pfs_pkg::OFS_DIR);
  wire sel_data   = hit(paddr, pfs_pkg::OFS_DATA);
  wire sel_pullup = hit(paddr, pfs_pkg::OFS_PULLUP);
  wire sel_level  = hit(paddr, pfs_pkg::OFS_LEVEL);
  wire sel_status = hit(paddr, pfs_pkg::OFS_STATUS);
  wire mapped     = sel_ctrl | sel_serial | sel_dir | sel_data
                  | sel_pullup | sel_level | sel_status;
  wire setup_ph   = psel & ~penable;
  wire access_ph  = psel & penable;
  wire wr_en      = access_ph & pwrite & mapped;

  // Control fields.
  wire       xtal_sel  = ctrl_reg[pfs_pkg::CTRL_XTAL_SEL];
  wire       sub_stop  = ctrl_reg[pfs_pkg::CTRL_SUB_STOP];
  wire       fb_off    = ctrl_reg[pfs_pkg::CTRL_FB_OFF];
  wire       irq0_en   = ctrl_reg[pfs_pkg::CTRL_IRQ0_EN];
  wire       rtc_sel   = ctrl_reg[pfs_pkg::CTRL_RTC_SEL];
  wire       rtc_en    = ctrl_reg[pfs_pkg::CTRL_RTC_EN];
  wire [2:0] smode     = serial_reg[pfs_pkg::SER_MODE_LSB +: 3];
  wire       serial_clock_direction     = serial_reg[pfs_pkg::SER_SERIAL_CLOCK_DIRECTION];
  wire       od_sel    = serial_reg[pfs_pkg::SER_OD];

  // Sub-clock pins.
  // buffer and feedback
  wire osc_buf = xtal_sel & ~sub_stop;
  wire fb_on   = xtal_sel & ~fb_off;

  logic [N-1:0] use_out;
  logic [N-1:0] out_data;
  logic [N-1:0] pull_req;
  logic [N-1:0] pad_od;

  assign use_out[pfs_pkg::PIN_XIN]  = ~xtal_sel & dir_reg[pfs_pkg::PIN_XIN];
  assign out_data[pfs_pkg::PIN_XIN] = data_reg[pfs_pkg::PIN_XIN];

  assign use_out[pfs_pkg::PIN_XOUT] =
    xtal_sel ? osc_buf : dir_reg[pfs_pkg::PIN_XOUT];
  assign out_data[pfs_pkg::PIN_XOUT] =
    xtal_sel ? ~pin_sync[pfs_pkg::PIN_XIN] : data_reg[pfs_pkg::PIN_XOUT];

  assign use_out[pfs_pkg::PIN_IRQ]  = dir_reg[pfs_pkg::PIN_IRQ];
  assign out_data[pfs_pkg::PIN_IRQ] = data_reg[pfs_pkg::PIN_IRQ];
  wire irq_feed = irq0_en & ~dir_reg[pfs_pkg::PIN_IRQ];

  wire ser_on = (smode != pfs_pkg::SMODE_PORT);
  assign use_out[pfs_pkg::PIN_TX]  = ser_on | dir_reg[pfs_pkg::PIN_TX];
  assign out_data[pfs_pkg::PIN_TX] =
    ser_on ? periph_src.serial_two_tx : data_reg[pfs_pkg::PIN_TX];

  assign use_out[pfs_pkg::PIN_RX]  = dir_reg[pfs_pkg::PIN_RX];
  assign out_data[pfs_pkg::PIN_RX] = data_reg[pfs_pkg::PIN_RX];

  // Clock pin: RTC has priority, then synchronous serial clock.
  // clock pin outputs
  wire rtc_drive = LARGE_VARIANT & rtc_sel & rtc_en;
  wire ck_drive  = LARGE_VARIANT & ~rtc_sel & ~serial_clock_direction
                 & (smode == pfs_pkg::SMODE_CLKSY);
  wire ck_feed   = LARGE_VARIANT & ~rtc_sel & serial_clock_direction
                 & ~dir_reg[pfs_pkg::PIN_CLK];
  assign use_out[pfs_pkg::PIN_CLK] =
    rtc_drive | ck_drive | dir_reg[pfs_pkg::PIN_CLK];
  assign out_data[pfs_pkg::PIN_CLK] =
    rtc_drive ? periph_src.rtc_out :
    ck_drive  ? periph_src.serial_two_clock :
                data_reg[pfs_pkg::PIN_CLK];

  // Pull-up requests; the crystal pins take no pull-up while crystal select is set.
  assign pull_req[pfs_pkg::PIN_XIN]  =
    ~xtal_sel & pullup_reg[pfs_pkg::PU_XIN];
  assign pull_req[pfs_pkg::PIN_XOUT] =
    ~xtal_sel & pullup_reg[pfs_pkg::PU_XIN];
  assign pull_req[pfs_pkg::PIN_IRQ]  = pullup_reg[pfs_pkg::PU_IRQ];
  assign pull_req[pfs_pkg::PIN_TX]   = pullup_reg[pfs_pkg::PU_TX];
  assign pull_req[pfs_pkg::PIN_RX]   = pullup_reg[pfs_pkg::PU_RX_CLK];
  assign pull_req[pfs_pkg::PIN_CLK]  = pullup_reg[pfs_pkg::PU_RX_CLK];

  assign pad_od = (ser_on & od_sel) ? (N'(1) << pfs_pkg::PIN_TX) : '0;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      pfs_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pad_in[g]),
        .q       (pin_sync[g])
      );
      pfs_pad u_pad (
        .use_out    (use_out[g]),
        .data       (out_data[g]),
        .open_drain (pad_od[g]),
        .pull_req   (pull_req[g]),
        .level      (pads.level[g]),
        .drive_n    (pads.drive_n[g]),
        .pull_on    (pads.pull_on[g])
      );
    end
  endgenerate

  // Serial receive and clock inputs idle high when the pin is not routed to them.
  // receive when input
  assign periph_dst.serial_two_rx =
    ~dir_reg[pfs_pkg::PIN_RX] ? pin_sync[pfs_pkg::PIN_RX] : 1'b1;
  assign periph_dst.serial_two_clock =
    ck_feed ? pin_sync[pfs_pkg::PIN_CLK] : 1'b1;
  assign periph_dst.ext_irq_zero = irq_feed & pin_sync[pfs_pkg::PIN_IRQ];
  // The sub-clock is sampled, so only slow external clocks pass intact.
  assign periph_dst.subclk_in     = osc_buf & pin_sync[pfs_pkg::PIN_XIN];
  assign periph_dst.osc_buffer_on = osc_buf;
  assign periph_dst.feedback_on   = fb_on;

  // Register write path.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg   <= pfs_pkg::CTRL_RST;
      serial_reg <= pfs_pkg::SERIAL_RST;
      dir_reg    <= pfs_pkg::DIR_RST;
      data_reg   <= pfs_pkg::DATA_RST;
      pullup_reg <= pfs_pkg::PULLUP_RST;
    end
    else if (wr_en)
    begin
      if (sel_ctrl)
        ctrl_reg <= pwdata[pfs_pkg::CTRL_W-1:0];
      if (sel_serial)
        serial_reg <= pwdata[pfs_pkg::SER_W-1:0];
      if (sel_dir)
        dir_reg <= pwdata[N-1:0];
      if (sel_data)
        data_reg <= pwdata[N-1:0];
      if (sel_pullup)
        pullup_reg <= pwdata[pfs_pkg::PU_W-1:0];
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop.
  wire [31:0] status_word = 32'(
    (32'(use_out) << pfs_pkg::STS_OUT_LSB)
    | (32'(osc_buf) << pfs_pkg::STS_OSC_BUF)
    | (32'(fb_on) << pfs_pkg::STS_FB_ON));
  wire [31:0] rd_word =
    sel_ctrl   ? 32'(ctrl_reg)   :
    sel_serial ? 32'(serial_reg) :
    sel_dir    ? 32'(dir_reg)    :
    sel_data   ? 32'(data_reg)   :
    sel_pullup ? 32'(pullup_reg) :
    sel_level  ? 32'(pin_sync)   :
    sel_status ? status_word     : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (setup_ph)
      prdata_reg <= rd_word;
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;

endmodule

// ==== test/pfs_pin_select_asserts.sv ====
// Purpose: Port-level assertions for the pin function select block.
// Assumes: Zero-wait APB and two-flop pin synchronisers.
// Notes:   Sees only top-level ports; bound from the testbench.
`timescale 1ns/1ps
module pfs_pin_select_asserts (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic [pfs_pkg::NPIN-1:0] pad_in,
  input wire pfs_pkg::pfs_pads_t       pads,
  input wire pfs_pkg::pfs_periph_src_t periph_src,
  input wire pfs_pkg::pfs_periph_dst_t periph_dst
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_high: assert property (pready)
    else $error("pready low");
  a_reset_inputs: assert property ($rose(presetn) |->
    pads.drive_n[5:2] == 4'hF && pads.pull_on == 6'h00)
    else $error("pin not input after reset");
  a_reset_xtal: assert property ($rose(presetn) |->
    pads.drive_n[1:0] == 2'h1)
    else $error("crystal pins wrong after reset");
  a_pullup_input: assert property (
    (pads.pull_on & ~pads.drive_n) == 6'h00)
    else $error("pull-up on a driven pin");
  a_irq_input: assert property (periph_dst.ext_irq_zero |->
    pads.drive_n[pfs_pkg::PIN_IRQ])
    else $error("interrupt fed from output pin");
  // Two edges of synchroniser delay, so reset history is skipped.
  a_rx_sync: assert property (pads.drive_n[pfs_pkg::PIN_RX] &&
    $past(presetn, 2) |->
    periph_dst.serial_two_rx == $past(pad_in[pfs_pkg::PIN_RX], 2))
    else $error("receive data not from pin");
  a_rx_blocked: assert property (!pads.drive_n[pfs_pkg::PIN_RX] |->
    periph_dst.serial_two_rx)
    else $error("receive data taken from output pin");
  a_osc_invert: assert property (periph_dst.osc_buffer_on |->
    !pads.drive_n[1] && pads.level[1] != periph_dst.subclk_in)
    else $error("sub-clock output not inverted input");
  a_osc_off: assert property (!periph_dst.osc_buffer_on |->
    !periph_dst.subclk_in)
    else $error("sub-clock passes with buffer off");
  a_fb_xin: assert property (periph_dst.feedback_on |->
    pads.drive_n[pfs_pkg::PIN_XIN])
    else $error("feedback on while crystal pin driven");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_err_mapped: assert property (psel && penable &&
    paddr[7:2] <= 6'h06 |-> !pslverr)
    else $error("error on mapped address");
endmodule

// ==== test/pfs_pin_select_tb.sv ====
// Purpose: Self-checking bench for the pin function select block.
// Assumes: Pin levels are static; the bench drives them directly.
// Notes:   Level is compared only on pins the block drives.
`timescale 1ns/1ps
module pfs_pin_select_tb;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [4:0] ser;
    logic [5:0] dir;
    logic [5:0] dat;
    logic [3:0] pu;
    logic [2:0] src;
    logic [5:0] drv;
    logic [5:0] lvl;
    logic [5:0] pul;
    logic [5:0] dst;
  } pfs_row_t;

  logic                     pclk;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [7:0]               paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic [5:0]               pad_in;
  pfs_pkg::pfs_pads_t       pads;
  pfs_pkg::pfs_periph_src_t periph_src;
  pfs_pkg::pfs_periph_dst_t periph_dst;
  logic [31:0]              rd;
  logic                     er;
  int                       error_cnt = 0;
  int                       n_tests = 0;
  int                       cyc = 0;
  // Columns: ctrl ser dir data pullup src | drive_n level pullup dst.
  pfs_row_t rows [9] = '{
    '{6'h00,5'h00,6'h3F,6'h2A,4'hF,3'h0,6'h00,6'h2A,6'h00,6'h03},
    '{6'h08,5'h00,6'h00,6'h3F,4'hE,3'h0,6'h3F,6'h00,6'h3C,6'h05},
    '{6'h00,5'h11,6'h00,6'h00,4'hA,3'h6,6'h1F,6'h20,6'h14,6'h01},
    '{6'h30,5'h11,6'h00,6'h00,4'hA,3'h1,6'h17,6'h20,6'h14,6'h01},
    '{6'h20,5'h02,6'h00,6'h00,4'hA,3'h4,6'h37,6'h08,6'h34,6'h01},
    '{6'h00,5'h08,6'h00,6'h00,4'h0,3'h0,6'h3F,6'h00,6'h00,6'h00},
    '{6'h03,5'h00,6'h3F,6'h3F,4'h0,3'h0,6'h03,6'h3C,6'h00,6'h13},
    '{6'h05,5'h00,6'h00,6'h00,4'h0,3'h0,6'h3D,6'h00,6'h00,6'h29},
    '{6'h01,5'h00,6'h02,6'h02,4'h0,3'h0,6'h3D,6'h00,6'h00,6'h39}};

  pfs_pin_select pfs_pin_select_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pad_in, .pads, .periph_src, .periph_dst);

  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Sample at the falling edge so that all pin outputs have settled.
  task automatic pins(input pfs_row_t r);
    @(negedge pclk);
    chk({26'h0, pads.drive_n}, {26'h0, r.drv});
    chk({26'h0, pads.level & ~r.drv}, {26'h0, r.lvl});
    chk({26'h0, pads.pull_on}, {26'h0, r.pul});
    chk({26'h0, periph_dst}, {26'h0, r.dst});
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      close_out;
    end
  end

  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pad_in = 6'h05;
    periph_src = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    pins(rows[8]);
    apb(1'h0, pfs_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, pfs_pkg::OFS_DIR, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      periph_src <= rows[i].src;
      apb(1'h1, pfs_pkg::OFS_CTRL, {26'h0, rows[i].ctrl});
      apb(1'h1, pfs_pkg::OFS_SERIAL, {27'h0, rows[i].ser});
      apb(1'h1, pfs_pkg::OFS_DIR, {26'h0, rows[i].dir});
      apb(1'h1, pfs_pkg::OFS_DATA, {26'h0, rows[i].dat});
      apb(1'h1, pfs_pkg::OFS_PULLUP, {28'h0, rows[i].pu});
      pins(rows[i]);
      $display("row %0d done", i);
    end
    apb(1'h1, pfs_pkg::OFS_SERIAL, 32'hFFFFFFFF);
    apb(1'h0, pfs_pkg::OFS_SERIAL, 32'h0);
    chk(rd, 32'h1F);
    apb(1'h0, pfs_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'hCA);
    apb(1'h1, pfs_pkg::OFS_LEVEL, 32'h0);
    apb(1'h0, pfs_pkg::OFS_LEVEL, 32'h0);
    chk(rd, 32'h05);
    apb(1'h0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("register test done");
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    pins(rows[8]);
    $display("mid-run reset test done");
    close_out;
  end
endmodule

bind pfs_pin_select pfs_pin_select_asserts pfs_pin_select_asserts_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pad_in, .pads, .periph_src, .periph_dst);
